// *** gauge_config_decode.sv ***
// Configuration store and decoder of a battery fuel gauge, APB slave
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "gauge_config_decode_consts.svh"

// Contract
// R01 - Coulomb counter result is multiplied by the stored 32-bit gain correction.
// R02 - Each conversion is scaled to mAh by the 16-bit sense resistor gain.
// R03 - Before sleep the three offset registers take fresh measured values.
// R04 - Filter threshold equals filter byte times 290 nV.
// R05 - Design capacity reported as stored (mAh) or times voltage in 10 mWh.
// R06 - Time and capacity alarm thresholds drive the two alarm outputs.
// R07 - Cycle count increments each time discharged charge reaches the threshold.
// R08 - Added charge is scaled by efficiency byte plus one over 256.
// R09 - Pack bit 7 picks relative (set) or absolute charge for LEDs.
// R10 - LED count field: 00 five, 01 three, 10 four, 11 five.
// R11 - Bits 4 and 3 enable PEC on host alarms and charger broadcasts.
// R12 - Broadcast disable bit blocks all broadcasts whatever battery mode says.
// R13 - Cell count field: 11 four, 10 three, 01 two cells.
// R14 - Fixed lowest limit stays stored; limits one and two never below it.
// R15 - When enabled, charge termination loads remaining capacity from full capacity.
// R16 - Gauge bit 5 selects independent charger learning when set.
// R17 - Compensation bit picks computed limits, otherwise the stored fixed limits.
// R18 - Gauge bit 3 picks pack voltage, else lowest cell, for discharge end.
// R19 - Overvoltage uses pack voltage, or highest cell times cell count.
// R20 - Bit 1 enables continuous midrange correction; bit 0 one correction after reset.
// R21 - Misc bit 15 selects the internal temperature sensor.
// R22 - Bit 13 enables front-end checks; with fail config bit 3 flags failure.
// R23 - Sleep after bus lines low 2 s unless sleep inhibit is set.
// R24 - Overtemperature switches the FET off only when the action bit is set.
// R25 - Charge LED bit enables the display while charging.
// R26 - Cell fault delay bit holds cell fault flags back by 1 s.
// R27 - Software writes misc high bit 14 as zero and bit 9 as one.
// R28 - Configuration is loaded after reset and applied before gauging starts.
module gauge_config_decode
   import gauge_config_decode_pkg::*;
#(
   parameter int SLEEP_IDLE_CYCLES = `SLEEP_IDLE_MS * `CLK_MHZ * 1000,
   parameter int CELL_DELAY_CYCLES = `CELL_FLAG_DELAY_MS * `CLK_MHZ * 1000,
   parameter int SYNC_PERCENT = 100
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ccStrobe,
   input wire logic signed [15:0] ccRaw,
   output logic signed [31:0] ccCorrected,
   output logic ccValid,
   input wire logic [15:0] chargeIn,
   output logic [15:0] chargeScaled,
   input wire logic mwhMode,
   output logic [15:0] designCapReport,
   output logic [16:0] filterThresholdNv,
   input wire logic [15:0] runTimeMin,
   input wire logic [15:0] remainingCapacity,
   output logic timeAlarm,
   output logic capAlarm,
   input wire logic dischargeStrobe,
   input wire logic [15:0] dischargeMah,
   output logic [15:0] cycleCount,
   output logic [15:0] fullCapInit,
   output logic ledSourceRelative,
   output logic [2:0] ledSegments,
   output logic hostAlarmPecEn,
   output logic chargerBcastPecEn,
   input wire logic modeBroadcastEn,
   output logic broadcastEn,
   output logic [2:0] seriesCells,
   input wire logic [15:0] compLimit0,
   input wire logic [15:0] compLimit1,
   input wire logic [15:0] compLimit2,
   output logic [15:0] endLimit0,
   output logic [15:0] endLimit1,
   output logic [15:0] endLimit2,
   input wire logic chargeTerminated,
   input wire logic [15:0] fullCapacity,
   output logic rmLoad,
   output logic [15:0] rmLoadValue,
   output logic independentLearning,
   input wire logic [15:0] packVoltage,
   input wire logic [15:0] minCellVoltage,
   input wire logic [15:0] maxCellVoltage,
   input wire logic [15:0] safetyOvLimit,
   output logic [15:0] endCompareVoltage,
   output logic safetyOv,
   output logic midrangeContinuous,
   output logic midrangeOnce,
   output logic internalTempSel,
   output logic frontEndCheckEn,
   output logic frontEndPfEn,
   input wire logic smbClkIn,
   input wire logic smbDataIn,
   input wire logic [15:0] ccOffsetMeas,
   input wire logic [7:0] gndOffsetMeas,
   input wire logic [7:0] convOffsetMeas,
   output logic sleepEnter,
   input wire logic overTemp,
   output logic fetOff,
   input wire logic charging,
   output logic ledEnable,
   input wire logic cellOvRaw,
   input wire logic cellUvRaw,
   output logic cellOvFlag,
   output logic cellUvFlag,
   output logic gaugingEnable
);
   localparam int NSLOT = 23;
   localparam logic [4:0] NONE = 5'h1f;

   if (SLEEP_IDLE_CYCLES < 1 || SLEEP_IDLE_CYCLES >= 2**28 ||
       CELL_DELAY_CYCLES < 1 || CELL_DELAY_CYCLES >= 2**28 ||
       SYNC_PERCENT < 0 || SYNC_PERCENT > 100) begin : bad_params
      $error("gauge_config_decode: parameter out of range");
   end

   // ************************************************************
   // Address decode
   // ************************************************************
   function automatic logic [4:0] slotOf(input logic [11:0] idx);
      case (idx)
         `IDX_REM_TIME_ALARM: slotOf = 5'd0;
         `IDX_DESIGN_VOLTAGE: slotOf = 5'd1;
         `IDX_CYCLE_INIT: slotOf = 5'd2;
         `IDX_PACK_OPTIONS: slotOf = 5'd3;
         `IDX_GAUGE_OPTIONS: slotOf = 5'd4;
         `IDX_MISC_HIGH: slotOf = 5'd5;
         `IDX_FILTER: slotOf = 5'd6;
         `IDX_DESIGN_CAP: slotOf = 5'd7;
         `IDX_FULL_CAP_INIT: slotOf = 5'd8;
         `IDX_CYCLE_THRESH: slotOf = 5'd9;
         `IDX_CHARGE_EFF: slotOf = 5'd10;
         `IDX_SENSE_GAIN: slotOf = 5'd11;
         `IDX_CC_GAIN_DELTA: slotOf = 5'd12;
         `IDX_COULOMB_OFFSET_CAL: slotOf = 5'd13;
         `IDX_GND_OFFSET: slotOf = 5'd14;
         `IDX_CONV_OFFSET: slotOf = 5'd15;
         `IDX_FAIL_CFG: slotOf = 5'd16;
         `IDX_CAP_ALARM: slotOf = 5'd17;
         `IDX_END_LIMIT_0: slotOf = 5'd18;
         `IDX_END_LIMIT_1: slotOf = 5'd19;
         `IDX_END_LIMIT_2: slotOf = 5'd20;
         `IDX_CONTROL: slotOf = 5'd21;
         `IDX_STATUS: slotOf = 5'd22;
         default: slotOf = NONE;
      endcase
   endfunction

   // Byte-wide fields keep only their low eight bits
   function automatic word_t slotMask(input logic [4:0] s);
      case (s)
         5'd3, 5'd4, 5'd5, 5'd6, 5'd10, 5'd14, 5'd15, 5'd16: slotMask = 32'h000000ff;
         5'd12: slotMask = 32'hffffffff;
         5'd21: slotMask = 32'h00000001;
         default: slotMask = 32'h0000ffff;
      endcase
   endfunction

   word_t regFile_reg [NSLOT];
   word_t regFile_next [NSLOT];
   gauge_state_e state_reg, state_next;
   logic [27:0] idleCnt_reg, idleCnt_next;
   logic [27:0] ovCnt_reg, ovCnt_next;
   logic [27:0] uvCnt_reg, uvCnt_next;
   logic [16:0] dischAcc_reg, dischAcc_next;
   logic [15:0] cycle_reg, cycle_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [4:0] slot;
   logic access;
   logic [7:0] pack, gauge, misc;
   logic [16:0] dischSum;
   logic [31:0] capProduct;
   logic [31:0] capMwh;
   logic [31:0] rmProduct;
   logic [63:0] gainProduct;
   logic [18:0] ovProduct;

   assign slot = slotOf(paddr[13:2]);
   assign access = psel && penable;
   assign pready = 1'b1;
   assign pslverr = access && slot == NONE;
   assign prdata = rdata_reg;
   assign pack = regFile_reg[3][7:0];
   assign gauge = regFile_reg[4][7:0];
   assign misc = regFile_reg[5][7:0];
   assign cycleCount = cycle_reg;

   // ************************************************************
   // Register file, sequencing and counters
   // ************************************************************
   always_comb begin
      regFile_next = regFile_reg;
      state_next = state_reg;
      idleCnt_next = 28'h0000000;
      ovCnt_next = 28'h0000000;
      uvCnt_next = 28'h0000000;
      dischAcc_next = dischAcc_reg;
      cycle_next = cycle_reg;
      rdata_next = rdata_reg;
      dischSum = dischAcc_reg + {1'b0, dischargeMah};
      if (psel && !penable && !pwrite) begin
         if (slot == 5'd22) begin
            rdata_next = {13'h0000, state_reg, cycle_reg};
         end else if (slot != NONE) begin
            rdata_next = regFile_reg[slot];
         end else begin
            rdata_next = 32'h00000000;
         end
      end
      if (access && pwrite && slot != NONE && slot != 5'd22) begin
         regFile_next[slot] = pwdata & slotMask(slot);
      end
      case (state_reg)
         ST_LOAD: begin
            // Gauging waits until software sets the config-done bit in the control register
            cycle_next = regFile_reg[2][15:0]; // R28
            if (regFile_reg[21][`CTRL_CFG_DONE]) begin
               state_next = gauge[`GG_MID_ONCE] ? ST_ONCE : ST_RUN; // R28 R20
            end
         end
         ST_ONCE: state_next = ST_RUN;
         ST_RUN: begin
            if (!smbClkIn && !smbDataIn && !misc[`MS_SLEEP_INH]) begin
               idleCnt_next = idleCnt_reg + 28'h0000001; // R23
            end
            if (idleCnt_reg == 28'(SLEEP_IDLE_CYCLES - 1)) begin
               // Hardware refresh wins over a bus write in the same cycle
               regFile_next[13] = {16'h0000, ccOffsetMeas}; // R03
               regFile_next[14] = {24'h000000, gndOffsetMeas}; // R03
               regFile_next[15] = {24'h000000, convOffsetMeas}; // R03
               idleCnt_next = 28'h0000000;
            end
            if (dischargeStrobe) begin
               if (regFile_reg[9][15:0] != 16'h0000 &&
                   dischSum >= {1'b0, regFile_reg[9][15:0]}) begin
                  dischAcc_next = dischSum - {1'b0, regFile_reg[9][15:0]}; // R07
                  cycle_next = cycle_reg + 16'h0001; // R07
               end else begin
                  dischAcc_next = dischSum;
               end
            end
         end
         default: state_next = ST_LOAD;
      endcase
      if (cellOvRaw && ovCnt_reg != 28'(CELL_DELAY_CYCLES)) begin
         ovCnt_next = ovCnt_reg + 28'h0000001; // R26
      end else if (cellOvRaw) begin
         ovCnt_next = ovCnt_reg;
      end
      if (cellUvRaw && uvCnt_reg != 28'(CELL_DELAY_CYCLES)) begin
         uvCnt_next = uvCnt_reg + 28'h0000001; // R26
      end else if (cellUvRaw) begin
         uvCnt_next = uvCnt_reg;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NSLOT; i++) begin
            regFile_reg[i] <= `CFG_RESET;
         end
         state_reg <= ST_LOAD;
         idleCnt_reg <= 28'h0000000;
         ovCnt_reg <= 28'h0000000;
         uvCnt_reg <= 28'h0000000;
         dischAcc_reg <= 17'h00000;
         cycle_reg <= 16'h0000;
         rdata_reg <= 32'h00000000;
      end else begin
         regFile_reg <= regFile_next;
         state_reg <= state_next;
         idleCnt_reg <= idleCnt_next;
         ovCnt_reg <= ovCnt_next;
         uvCnt_reg <= uvCnt_next;
         dischAcc_reg <= dischAcc_next;
         cycle_reg <= cycle_next;
         rdata_reg <= rdata_next;
      end
   end

   // ************************************************************
   // Decoded settings and scaled values
   // ************************************************************
   // Gain correction is Q2.30: 0x40000000 leaves the count unchanged
   assign gainProduct = 64'(signed'(ccRaw) * signed'({1'b0, regFile_reg[11][15:0]})) *
      64'(signed'(regFile_reg[12])); // R01 R02
   assign capProduct = regFile_reg[7][15:0] * regFile_reg[1][15:0];
   assign capMwh = capProduct / `MWH_DIVISOR;
   assign rmProduct = fullCapacity * 16'(SYNC_PERCENT);
   assign ovProduct = maxCellVoltage * seriesCells;

   logic signed [31:0] ccCorr_next;
   logic [15:0] chargeScaled_next, designCap_next, lim0_next, lim1_next, lim2_next;
   logic [15:0] endCmp_next;
   logic [2:0] segs, cells;
   logic fetOff_next, ovFlag_next, uvFlag_next, safetyOv_next;
   always_comb begin
      ccCorr_next = ccStrobe ? gainProduct[61:30] : ccCorrected;
      chargeScaled_next = 16'((32'(chargeIn) * ({1'b0, regFile_reg[10][7:0]} + 9'h001)) >> 8); // R08
      if (!mwhMode) begin
         designCap_next = regFile_reg[7][15:0]; // R05
      end else if (capMwh > 32'h0000ffff) begin
         designCap_next = 16'hffff;
      end else begin
         designCap_next = capMwh[15:0]; // R05
      end
      case ({pack[`PK_LED_HI], pack[`PK_LED_LO]})
         2'b01: segs = 3'd3; // R10
         2'b10: segs = 3'd4; // R10
         default: segs = 3'd5; // R10
      endcase
      case ({pack[`PK_CELLS_HI], pack[`PK_CELLS_LO]})
         2'b11: cells = 3'd4; // R13
         2'b10: cells = 3'd3; // R13
         2'b01: cells = 3'd2; // R13
         default: cells = 3'd4;
      endcase
      if (gauge[`GG_LIM_COMP]) begin
         lim0_next = gauge[`GG_FIXED_LIM0] ? regFile_reg[18][15:0] : compLimit0; // R17 R14
         lim1_next = compLimit1;
         lim2_next = compLimit2;
      end else begin
         lim0_next = regFile_reg[18][15:0]; // R17
         lim1_next = regFile_reg[19][15:0];
         lim2_next = regFile_reg[20][15:0];
      end
      if (gauge[`GG_FIXED_LIM0] && lim1_next < regFile_reg[18][15:0]) begin
         lim1_next = regFile_reg[18][15:0]; // R14
      end
      if (gauge[`GG_FIXED_LIM0] && lim2_next < regFile_reg[18][15:0]) begin
         lim2_next = regFile_reg[18][15:0]; // R14
      end
      endCmp_next = gauge[`GG_LIM_BASIS] ? packVoltage : minCellVoltage; // R18
      if (gauge[`GG_OV_BASIS]) begin
         safetyOv_next = ovProduct > {3'b000, safetyOvLimit}; // R19
      end else begin
         safetyOv_next = packVoltage > safetyOvLimit; // R19
      end
      fetOff_next = overTemp && misc[`MS_OT_FET]; // R24
      ovFlag_next = misc[`MS_CELL_DELAY] ? ovCnt_reg == 28'(CELL_DELAY_CYCLES) : cellOvRaw; // R26
      uvFlag_next = misc[`MS_CELL_DELAY] ? uvCnt_reg == 28'(CELL_DELAY_CYCLES) : cellUvRaw; // R26
   end
   assign seriesCells = cells;

   // Settings are registered so every decoded output except seriesCells changes one cycle after its write
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ccCorrected <= 32'sh00000000;
         ccValid <= 1'b0;
         chargeScaled <= 16'h0000;
         designCapReport <= 16'h0000;
         filterThresholdNv <= 17'h00000;
         timeAlarm <= 1'b0;
         capAlarm <= 1'b0;
         fullCapInit <= 16'h0000;
         ledSourceRelative <= 1'b0;
         ledSegments <= 3'd5;
         hostAlarmPecEn <= 1'b0;
         chargerBcastPecEn <= 1'b0;
         broadcastEn <= 1'b0;
         endLimit0 <= 16'h0000;
         endLimit1 <= 16'h0000;
         endLimit2 <= 16'h0000;
         rmLoad <= 1'b0;
         rmLoadValue <= 16'h0000;
         independentLearning <= 1'b0;
         endCompareVoltage <= 16'h0000;
         safetyOv <= 1'b0;
         midrangeContinuous <= 1'b0;
         midrangeOnce <= 1'b0;
         internalTempSel <= 1'b0;
         frontEndCheckEn <= 1'b0;
         frontEndPfEn <= 1'b0;
         sleepEnter <= 1'b0;
         fetOff <= 1'b0;
         ledEnable <= 1'b0;
         cellOvFlag <= 1'b0;
         cellUvFlag <= 1'b0;
         gaugingEnable <= 1'b0;
      end else begin
         ccCorrected <= ccCorr_next; // R01 R02
         ccValid <= ccStrobe;
         chargeScaled <= chargeScaled_next; // R08
         designCapReport <= designCap_next; // R05
         filterThresholdNv <= 17'(regFile_reg[6][7:0] * `FILTER_NV_PER_COUNT); // R04
         timeAlarm <= runTimeMin < regFile_reg[0][15:0]; // R06
         capAlarm <= remainingCapacity < regFile_reg[17][15:0]; // R06
         fullCapInit <= regFile_reg[8][15:0];
         ledSourceRelative <= pack[`PK_LED_SRC]; // R09
         ledSegments <= segs; // R10
         hostAlarmPecEn <= pack[`PK_HOST_PEC]; // R11
         chargerBcastPecEn <= pack[`PK_CHG_PEC]; // R11
         broadcastEn <= modeBroadcastEn && !pack[`PK_BCAST_DIS]; // R12
         endLimit0 <= lim0_next;
         endLimit1 <= lim1_next;
         endLimit2 <= lim2_next;
         rmLoad <= chargeTerminated && gauge[`GG_TERM_SYNC] && state_reg == ST_RUN; // R15
         rmLoadValue <= 16'(rmProduct / 32'd100); // R15
         independentLearning <= gauge[`GG_INDEP_CHG]; // R16
         endCompareVoltage <= endCmp_next; // R18
         safetyOv <= safetyOv_next; // R19
         midrangeContinuous <= gauge[`GG_MID_CONT] && state_reg == ST_RUN; // R20
         midrangeOnce <= state_reg == ST_ONCE; // R20
         internalTempSel <= misc[`MS_INT_TEMP]; // R21
         frontEndCheckEn <= misc[`MS_FE_CHECK]; // R22
         frontEndPfEn <= misc[`MS_FE_CHECK] && regFile_reg[16][`FAIL_CFG_FE]; // R22
         sleepEnter <= state_reg == ST_RUN &&
            idleCnt_reg == 28'(SLEEP_IDLE_CYCLES - 1); // R23 R03
         fetOff <= fetOff_next; // R24
         ledEnable <= !charging || misc[`MS_CHG_LED]; // R25
         cellOvFlag <= ovFlag_next; // R26
         cellUvFlag <= uvFlag_next; // R26
         gaugingEnable <= state_reg == ST_RUN; // R28
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   unmapped_err_a: assert property (@(posedge clock) disable iff (rst)
      access && slot == NONE |-> pslverr && (pwrite || prdata == 32'h00000000))
      else $error("unmapped access not refused");
   sleep_offsets_a: assert property (@(posedge clock) disable iff (rst) // R03
      sleepEnter |-> regFile_reg[13][15:0] == $past(ccOffsetMeas))
      else $error("offset not refreshed at sleep");
   sleep_inhibit_a: assert property (@(posedge clock) disable iff (rst) // R23
      $past(misc[`MS_SLEEP_INH], 2) && $past(misc[`MS_SLEEP_INH]) |-> !sleepEnter)
      else $error("sleep entered while inhibited");
   bcast_block_a: assert property (@(posedge clock) disable iff (rst) // R12
      $past(pack[`PK_BCAST_DIS]) |-> !broadcastEn) else $error("broadcast while disabled");
   limit_floor_a: assert property (@(posedge clock) disable iff (rst) // R14
      $past(gauge[`GG_FIXED_LIM0]) |-> endLimit1 >= $past(regFile_reg[18][15:0]) &&
      endLimit2 >= $past(regFile_reg[18][15:0])) else $error("limit below fixed floor");
   led_three_a: assert property (@(posedge clock) disable iff (rst) // R10
      $past(pack[6:5]) == 2'b01 |-> ledSegments == 3'd3) else $error("wrong LED count");
   cell_delay_a: assert property (@(posedge clock) disable iff (rst) // R26
      misc[`MS_CELL_DELAY] && $past(misc[`MS_CELL_DELAY]) && !$past(cellOvRaw) |=> !cellOvFlag)
      else $error("cell fault flag not delayed");
   fet_action_a: assert property (@(posedge clock) disable iff (rst) // R24
      overTemp && misc[`MS_OT_FET] |=> fetOff) else $error("FET not switched off");
   cycle_step_a: assert property (@(posedge clock) disable iff (rst) // R07
      cycle_reg != $past(cycle_reg) && $past(state_reg) == ST_RUN |->
      $past(dischargeStrobe) && cycle_reg == $past(cycle_reg) + 16'h0001)
      else $error("cycle count moved without threshold");
   gauge_hold_a: assert property (@(posedge clock) disable iff (rst) // R28
      state_reg == ST_LOAD && !regFile_reg[21][`CTRL_CFG_DONE] |=> !gaugingEnable)
      else $error("gauging before load");
endmodule // gauge_config_decode
`default_nettype wire

// *** gauge_config_decode_consts.svh ***
// Register indexes, reset values and timing figures for the gauge configuration store
`ifndef GAUGE_CONFIG_DECODE_CONSTS_SVH
`define GAUGE_CONFIG_DECODE_CONSTS_SVH
// Register indexes and reset value; byte address is four times the index
`define IDX_REM_TIME_ALARM 12'h002
`define IDX_DESIGN_VOLTAGE 12'h004
`define IDX_CYCLE_INIT 12'h00c
`define IDX_PACK_OPTIONS 12'h028
`define IDX_GAUGE_OPTIONS 12'h029
`define IDX_MISC_HIGH 12'h02a
`define IDX_FILTER 12'h02c
`define IDX_DESIGN_CAP 12'h032
`define IDX_FULL_CAP_INIT 12'h036
`define IDX_CYCLE_THRESH 12'h037
`define IDX_CHARGE_EFF 12'h054
`define IDX_SENSE_GAIN 12'hcb
`define IDX_CC_GAIN_DELTA 12'hcd
`define IDX_COULOMB_OFFSET_CAL 12'hd2
`define IDX_GND_OFFSET 12'hd4
`define IDX_CONV_OFFSET 12'hd5
`define IDX_FAIL_CFG 12'h11f
`define IDX_END_LIMIT_0 12'h137
`define IDX_CAP_ALARM 12'h180
`define IDX_END_LIMIT_1 12'h181
`define IDX_END_LIMIT_2 12'h182
`define IDX_CONTROL 12'h183
`define IDX_STATUS 12'h184
`define CFG_RESET 32'h00000000
// Pack options fields
`define PK_LED_SRC 7
`define PK_LED_HI 6
`define PK_LED_LO 5
`define PK_HOST_PEC 4
`define PK_CHG_PEC 3
`define PK_BCAST_DIS 2
`define PK_CELLS_HI 1
`define PK_CELLS_LO 0
// Gauge options fields
`define GG_FIXED_LIM0 7
`define GG_TERM_SYNC 6
`define GG_INDEP_CHG 5
`define GG_LIM_COMP 4
`define GG_LIM_BASIS 3
`define GG_OV_BASIS 2
`define GG_MID_CONT 1
`define GG_MID_ONCE 0
// Misc options high byte, fail config and control fields
`define MS_INT_TEMP 7
`define MS_FE_CHECK 5
`define MS_SLEEP_INH 4
`define MS_OT_FET 3
`define MS_CHG_LED 2
`define MS_CELL_DELAY 0
`define FAIL_CFG_FE 3
`define CTRL_CFG_DONE 0
// Timing and scale factors
`define CLK_MHZ 100
`define SLEEP_IDLE_MS 2000
`define CELL_FLAG_DELAY_MS 1000
`define FILTER_NV_PER_COUNT 290
`define MWH_DIVISOR 10000
`endif

// *** gauge_config_decode_pkg.sv ***
// Types shared by the gauge configuration store
package gauge_config_decode_pkg;
   typedef enum logic [2:0] {
      ST_LOAD = 3'b001,
      ST_ONCE = 3'b010,
      ST_RUN = 3'b100
   } gauge_state_e;
   typedef logic [31:0] word_t;
endpackage

// *** smb_peer.sv ***
// Model of the host and charger on the management bus lines
`timescale 1ns/100ps
`default_nettype none
module smb_peer (
   input wire logic clock,
   input wire logic quiet,
   output logic smbClk,
   output logic smbData
);
   logic [3:0] cnt = 4'h0;
   always_ff @(posedge clock) cnt <= cnt + 4'h1;
   // Quiet models an unplugged host: both lines sit low, the sleep condition
   assign smbClk = quiet ? 1'b0 : cnt[1];
   assign smbData = quiet ? 1'b0 : cnt[3];
endmodule // smb_peer
`default_nettype wire

// *** tb_top.sv ***
// Register bank testbench: APB tasks and decode checks
`timescale 1ns/100ps
`default_nettype none
`include "gauge_config_decode_consts.svh"
module tb_top;
   logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, quiet = 1'b0;
   logic ccStrobe = 1'b0, mwhMode = 1'b0, dischargeStrobe = 1'b0, modeBroadcastEn = 1'b1;
   logic chargeTerminated = 1'b0, overTemp = 1'b0, charging = 1'b0, cellOvRaw = 1'b0;
   logic cellUvRaw = 1'b0, err;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h00000000, prdata, rdat;
   logic signed [15:0] ccRaw = 16'sh0010;
   logic signed [31:0] ccCorrected;
   logic [15:0] chargeIn = 16'h03e8, runTimeMin = 16'h0009, remainingCapacity = 16'h0000;
   logic [15:0] dischargeMah = 16'h0000, fullCapacity = 16'h0000, ccOffsetMeas = 16'h1234;
   logic [15:0] compLimit0 = 16'h0000, compLimit1 = 16'h0000, compLimit2 = 16'h0000;
   logic [15:0] packVoltage = 16'h0000, minCellVoltage = 16'h0000, maxCellVoltage = 16'h0000;
   logic [15:0] safetyOvLimit = 16'h0000;
   logic [7:0] gndOffsetMeas = 8'h26, convOffsetMeas = 8'h27;
   logic pready, pslverr, ccValid, timeAlarm, capAlarm, rmLoad, ledSourceRelative;
   logic hostAlarmPecEn, chargerBcastPecEn, broadcastEn, independentLearning, safetyOv;
   logic midrangeContinuous, midrangeOnce, internalTempSel, frontEndCheckEn, frontEndPfEn;
   logic sleepEnter, fetOff, ledEnable, cellOvFlag, cellUvFlag, gaugingEnable, smbClkIn, smbDataIn;
   logic [15:0] chargeScaled, designCapReport, cycleCount, fullCapInit, endLimit0, endLimit1;
   logic [15:0] endLimit2, rmLoadValue, endCompareVoltage;
   logic [16:0] filterThresholdNv;
   logic [2:0] ledSegments, seriesCells;
   logic [2:0] segs [4] = '{3'h5, 3'h3, 3'h4, 3'h5};
   logic [2:0] cells [4] = '{3'h4, 3'h2, 3'h3, 3'h4};
   int errors = 0, n_compared = 0, k;
   gauge_config_decode #(.SLEEP_IDLE_CYCLES(20), .CELL_DELAY_CYCLES(10)) dut (.*);
   smb_peer peer (.clock(clock), .quiet(quiet), .smbClk(smbClkIn), .smbData(smbDataIn));
   // ************************
   // Bus and check tasks
   // ************************
   task automatic end_sim;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic req(input logic [11:0] i, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= d;
      @(posedge clock) penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         if (++n > 50) begin errors++; end_sim; end
         @(posedge clock);
      end
      err = pslverr;
      rdat = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] i, input logic [31:0] exp, input string nm);
      req(i, 1'b0, 32'h0);
      chk(nm, rdat, exp);
   endtask
   task automatic settle;
      repeat (3) @(posedge clock);
   endtask
   initial begin
      forever #5 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      errors++;
      end_sim;
   end
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      settle;
      chk("gauging", gaugingEnable, 0);
      for (k = 0; k < 4; k++) begin
         req(`IDX_PACK_OPTIONS, 1'b1, {k[0], k[1:0], k[0], ~k[0], k[1], k[1:0]});
         settle;
         chk("segments", ledSegments, segs[k]);
         chk("cells", seriesCells, cells[k]);
         chk("ledsrc", ledSourceRelative, k[0]);
         chk("hostpec", hostAlarmPecEn, k[0]);
         chk("chgpec", chargerBcastPecEn, !k[0]);
         chk("bcast", broadcastEn, !k[1]);
      end
      req(`IDX_FILTER, 1'b1, 32'h000000ff);
      req(`IDX_DESIGN_CAP, 1'b1, 32'h00000bb8);
      req(`IDX_DESIGN_VOLTAGE, 1'b1, 32'h00002a30);
      req(`IDX_REM_TIME_ALARM, 1'b1, 32'h0000000a);
      req(`IDX_CHARGE_EFF, 1'b1, 32'h0000007f);
      req(`IDX_CAP_ALARM, 1'b1, 32'h00000010);
      settle;
      chk("capalarm", capAlarm, 1);
      chk("filter", filterThresholdNv, 32'h000120de);
      chk("capmah", designCapReport, 32'h00000bb8);
      chk("timealarm", timeAlarm, 1);
      chk("effic", chargeScaled, 32'h000001f4);
      mwhMode <= 1'b1;
      runTimeMin <= 16'h000a;
      settle;
      chk("capmwh", designCapReport, 32'h00000ca8);
      chk("timeclear", timeAlarm, 0);
      rd(`IDX_DESIGN_VOLTAGE, 32'h00002a30, "voltage");
      rd(12'h3ff, 32'h0, "unmapped");
      chk("slverr", err, 1);
      req(`IDX_MISC_HIGH, 1'b1, 32'h0000000a);
      charging <= 1'b1;
      overTemp <= 1'b1;
      req(`IDX_CONTROL, 1'b1, 32'h00000001);
      settle;
      chk("running", gaugingEnable, 1);
      chk("fetoff", fetOff, 1);
      chk("ledoff", ledEnable, 0);
      req(`IDX_CYCLE_THRESH, 1'b1, 32'h00000064);
      dischargeMah <= 16'h003c;
      dischargeStrobe <= 1'b1;
      repeat (2) @(posedge clock);
      dischargeStrobe <= 1'b0;
      settle;
      chk("cycles", cycleCount, 1);
      quiet <= 1'b1;
      k = 0;
      while (sleepEnter !== 1'b1 && k < 100) begin k++; @(posedge clock); end
      chk("sleep", k < 100, 1);
      rd(`IDX_COULOMB_OFFSET_CAL, 32'h00001234, "ccoffset");
      rd(`IDX_CONV_OFFSET, 32'h00000027, "convoffset");
      req(`IDX_MISC_HIGH, 1'b1, 32'h00000017);
      settle;
      chk("fetkeep", fetOff, 0);
      chk("ledon", ledEnable, 1);
      k = 0;
      repeat (60) begin @(posedge clock); if (sleepEnter === 1'b1) k++; end
      chk("nosleep", k, 0);
      cellOvRaw <= 1'b1;
      repeat (5) @(posedge clock);
      chk("ovhold", cellOvFlag, 0);
      repeat (10) @(posedge clock);
      chk("ovflag", cellOvFlag, 1);
      end_sim;
   end
endmodule // tb_top
`default_nettype wire
